// file: token_crc_pkg.sv
// Shared constants, codes and CRC step functions for the token and data field logic
package token_crc_pkg;
  localparam int PID_BITS = 8;
  localparam int TOKEN_BITS = 24;
  localparam int SPLIT_BITS = 32;
  localparam int ADDR_LSB = 8;
  localparam int ADDR_W = 7;
  localparam int ENDP_LSB = 15;
  localparam int ENDP_W = 4;
  localparam int FRAME_LSB = 8;
  localparam int FRAME_W = 11;
  localparam int SPLIT_SC_BIT = 15;
  localparam int MAX_DATA_BYTES = 1024;
  localparam int CRC16_BYTES = 2;
  localparam int MAX_DATA_BITS = PID_BITS + 8 * (MAX_DATA_BYTES + CRC16_BYTES);
  localparam logic [4:0] TOKEN_BODY_BITS = 5'h0b;
  localparam logic [4:0] SPLIT_BODY_BITS = 5'h13;
  localparam logic [6:0] DEFAULT_ADDR = 7'h00;
  localparam logic [3:0] LOW_SPEED_MAX_ENDP = 4'h2;
  localparam logic [4:0] CRC5_SEED = 5'h1f;
  localparam logic [4:0] CRC5_POLY = 5'h05;
  localparam logic [4:0] CRC5_RESIDUAL = 5'h0c;
  localparam logic [15:0] CRC16_SEED = 16'hffff;
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] CRC16_RESIDUAL = 16'h800d;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SOF = 4'h5;
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_PING = 4'h4;
  localparam logic [3:0] PID_SPLIT = 4'h8;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hb;
  localparam logic [3:0] PID_DATA2 = 4'h7;
  localparam logic [3:0] PID_MDATA = 4'hf;

  function automatic logic [4:0] crc5Step(input logic [4:0] rem, input logic din);
    logic fb;
    fb = rem[4] ^ din;
    crc5Step = {rem[3:0], 1'b0} ^ (fb ? CRC5_POLY : 5'h00);
  endfunction

  function automatic logic [15:0] crc16Step(input logic [15:0] rem, input logic din);
    logic fb;
    fb = rem[15] ^ din;
    crc16Step = {rem[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
  endfunction

  function automatic logic pidIsData(input logic [3:0] pid);
    pidIsData = (pid == PID_DATA0) || (pid == PID_DATA1) || (pid == PID_DATA2) || (pid == PID_MDATA);
  endfunction
endpackage

// file: serial_link_if.sv
// Unstuffed bit link between the host end and the function end
`timescale 1ns/1ps
interface serial_link_if;
  logic hostBit;
  logic hostValid;
  logic hostEop;
  logic devBit;
  logic devValid;
  logic devEop;
  modport hostEnd (output hostBit, output hostValid, output hostEop, input devBit, input devValid, input devEop);
  modport deviceEnd (input hostBit, input hostValid, input hostEop, output devBit, output devValid, output devEop);
endinterface

// file: packet_sender.sv
// Serialiser for token and data packets with CRC generation
`timescale 1ns/1ps
module packet_sender (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [3:0] pid,
  input wire logic isData,
  input wire logic noData,
  input wire logic [18:0] body,
  input wire logic [4:0] bodyBits,
  input wire logic [7:0] byteData,
  input wire logic byteValid,
  input wire logic byteLast,
  output logic byteReady,
  output logic linkBit,
  output logic linkValid,
  output logic linkEop,
  output logic busy
);
  typedef enum logic [2:0] {S_IDLE, S_SHIFT, S_FETCH, S_CRC, S_EOP} sendState_t;
  typedef struct packed {
    sendState_t st;
    logic [26:0] sh;
    logic [4:0] last;
    logic [4:0] idx;
    logic [15:0] crc;
    logic data;
    logic fin;
    logic [10:0] bytes;
    logic byteReady;
    logic linkBit;
    logic linkValid;
    logic linkEop;
    logic busy;
  } sendRegs_t;

  sendRegs_t q;
  sendRegs_t next_q;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    next_q.linkValid = 1'b0;
    next_q.linkEop = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        next_q.busy = start;
        if (start) begin
          next_q.sh = {body, ~pid, pid};
          next_q.idx = 5'h00;
          next_q.data = isData;
          next_q.crc = isData ? token_crc_pkg::CRC16_SEED : {11'h000, token_crc_pkg::CRC5_SEED};
          next_q.last = isData ? 5'h07 : 5'(5'h07 + bodyBits);
          next_q.fin = noData;
          next_q.bytes = 11'h000;
          next_q.st = S_SHIFT;
        end
      end
      S_SHIFT: begin
        next_q.linkBit = q.sh[0];
        next_q.linkValid = 1'b1;
        next_q.sh = q.sh >> 1;
        next_q.idx = 5'(q.idx + 5'h01);
        if (q.idx >= 5'(token_crc_pkg::PID_BITS)) begin
          next_q.crc = q.data ? token_crc_pkg::crc16Step(q.crc, q.sh[0])
                              : {11'h000, token_crc_pkg::crc5Step(q.crc[4:0], q.sh[0])};
        end
        if (q.idx == q.last) begin
          if (q.data && !q.fin) begin
            next_q.byteReady = 1'b1;
            next_q.st = S_FETCH;
          end else begin
            next_q.idx = q.data ? 5'h0f : 5'h04;
            next_q.st = S_CRC;
          end
        end
      end
      S_FETCH: begin
        if (byteValid) begin
          next_q.byteReady = 1'b0;
          next_q.sh = {19'h00000, byteData};
          next_q.idx = 5'h08;
          next_q.last = 5'h0f;
          next_q.bytes = 11'(q.bytes + 11'h001);
          next_q.fin = byteLast || (11'(q.bytes + 11'h001) == 11'(token_crc_pkg::MAX_DATA_BYTES));
          next_q.st = S_SHIFT;
        end
      end
      S_CRC: begin
        next_q.linkBit = ~q.crc[q.idx[3:0]];
        next_q.linkValid = 1'b1;
        next_q.idx = 5'(q.idx - 5'h01);
        if (q.idx == 5'h00) begin
          next_q.st = S_EOP;
        end
      end
      S_EOP: begin
        next_q.linkEop = 1'b1;
        next_q.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= S_IDLE;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  assign byteReady = q.byteReady;
  assign linkBit = q.linkBit;
  assign linkValid = q.linkValid;
  assign linkEop = q.linkEop;
  assign busy = q.busy;
endmodule

// file: host_end.sv
// Host end: issues tokens, start-of-frame and data packets, receives data packets
`timescale 1ns/1ps
module host_end (
  input wire logic clk,
  input wire logic sys_rst,
  serial_link_if.hostEnd link,
  input wire logic tokenStart,
  input wire logic [3:0] tokenPid,
  input wire logic [6:0] tokenAddr,
  input wire logic [3:0] tokenEndp,
  input wire logic sofStart,
  input wire logic splitStart,
  input wire logic [18:0] splitBody,
  input wire logic dataStart,
  input wire logic [3:0] dataPid,
  input wire logic dataEmpty,
  input wire logic [7:0] txByte,
  input wire logic txByteValid,
  input wire logic txByteLast,
  output logic txByteReady,
  output logic busy,
  output logic [10:0] frameNum,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  output logic rxDone,
  output logic rxCrcOk
);
  typedef struct packed {
    logic [10:0] frameNum;
    logic [13:0] idx;
    logic [7:0] pidByte;
    logic [15:0] crc16;
    logic [7:0] cur;
    logic [15:0] hold;
    logic [1:0] held;
    logic [7:0] rxByte;
    logic rxByteValid;
    logic rxDone;
    logic rxCrcOk;
  } hostRegs_t;

  hostRegs_t q;
  hostRegs_t next_q;
  logic go;
  logic [3:0] goPid;
  logic [18:0] goBody;
  logic [4:0] goBits;
  logic goData;

  ////////////////////////////////////////////////////////////////
  assign go = !busy && (sofStart || tokenStart || splitStart || dataStart);
  always_comb begin
    goPid = dataPid;
    goBody = 19'h00000;
    goBits = 5'h00;
    goData = 1'b0;
    if (sofStart) begin
      goPid = token_crc_pkg::PID_SOF;
      goBody = {8'h00, q.frameNum};
      goBits = token_crc_pkg::TOKEN_BODY_BITS;
    end else if (tokenStart) begin
      goPid = tokenPid;
      goBody = {8'h00, tokenEndp, tokenAddr};
      goBits = token_crc_pkg::TOKEN_BODY_BITS;
    end else if (splitStart) begin
      goPid = token_crc_pkg::PID_SPLIT;
      goBody = splitBody;
      goBits = token_crc_pkg::SPLIT_BODY_BITS;
    end else begin
      goData = 1'b1;
    end
  end

  packet_sender sender (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(go),
    .pid(goPid),
    .isData(goData),
    .noData(dataEmpty),
    .body(goBody),
    .bodyBits(goBits),
    .byteData(txByte),
    .byteValid(txByteValid),
    .byteLast(txByteLast),
    .byteReady(txByteReady),
    .linkBit(link.hostBit),
    .linkValid(link.hostValid),
    .linkEop(link.hostEop),
    .busy(busy)
  );

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    next_q.rxByteValid = 1'b0;
    next_q.rxDone = 1'b0;
    if (go && sofStart) begin
      next_q.frameNum = 11'(q.frameNum + 11'h001);
    end
    if (link.devValid) begin
      if (q.idx != '1) next_q.idx = 14'(q.idx + 14'h0001);
      if (q.idx < 14'(token_crc_pkg::PID_BITS)) begin
        next_q.pidByte = {link.devBit, q.pidByte[7:1]};
      end else begin
        next_q.crc16 = token_crc_pkg::crc16Step(q.crc16, link.devBit);
        next_q.cur = {link.devBit, q.cur[7:1]};
        if (q.idx[2:0] == 3'h7) begin
          next_q.hold = {next_q.cur, q.hold[15:8]};
          if (q.held == 2'h2) begin
            next_q.rxByte = q.hold[7:0];
            next_q.rxByteValid = 1'b1;
          end else begin
            next_q.held = 2'(q.held + 2'h1);
          end
        end
      end
    end
    if (link.devEop) begin
      next_q.rxDone = 1'b1;
      next_q.rxCrcOk = (q.crc16 == token_crc_pkg::CRC16_RESIDUAL) && (q.idx[2:0] == 3'h0)
                       && (q.pidByte[7:4] == ~q.pidByte[3:0]) && token_crc_pkg::pidIsData(q.pidByte[3:0])
                       && (q.idx >= 14'(token_crc_pkg::PID_BITS + 16))
                       && (q.idx <= 14'(token_crc_pkg::MAX_DATA_BITS));
      next_q.idx = 14'h0000;
      next_q.crc16 = token_crc_pkg::CRC16_SEED;
      next_q.held = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.crc16 <= token_crc_pkg::CRC16_SEED;
    end else begin
      q <= next_q;
    end
  end

  assign frameNum = q.frameNum;
  assign rxByte = q.rxByte;
  assign rxByteValid = q.rxByteValid;
  assign rxDone = q.rxDone;
  assign rxCrcOk = q.rxCrcOk;
endmodule

// file: function_end.sv
// Function end: token decode and check, data packet receive and send
// How it works
// - Seven-bit address picks exactly one function
// - Address resets to zero until host sets
// - Four-bit endpoint field, endpoint zero fixed
// - Endpoint zero control pipe always present
// - Low speed: endpoints zero to two only
// - Address in tokens; endpoint not in split
// - Host frame counter increments, wraps, only SOF
// - Data field zero to 1024 bytes, LSb first
// - CRC covers all fields except the identifier
// - CRC runs on unstuffed bits both ways
// - CRC seeded all ones, shift with feedback
// - Sender appends inverted remainder, MSb first
// - Residual mismatch flags error, packet discarded; data bytes already passed out on rxByte
// - Stuffing of CRC bits left to line coder
// - Five-bit CRC guards all token bodies
// - Token CRC polynomial and residual checked
// - Data CRC sixteen bits with its residual
// - Token: identifier, address, endpoint, CRC order
// - Only the host ever sends tokens
// - Token valid only with end after 24 bits, split token after 32
// - Split token is four bytes, start/complete bit
// - IN, OUT, SETUP, PING reported to user
// - Address or endpoint mismatch ignores the token
// - Fields LSb first, bytes little endian
`timescale 1ns/1ps
module function_end (
  input wire logic clk,
  input wire logic sys_rst,
  serial_link_if.deviceEnd link,
  input wire logic setAddr,
  input wire logic [6:0] newAddr,
  input wire logic [15:0] epReady,
  input wire logic lowSpeed,
  output logic [6:0] devAddr,
  output logic tokenHit,
  output logic [3:0] tokenPid,
  output logic [3:0] tokenEndp,
  output logic sofSeen,
  output logic [10:0] frameNum,
  output logic splitSeen,
  output logic splitComplete,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  output logic rxDone,
  output logic rxCrcOk,
  output logic crcErr,
  input wire logic txStart,
  input wire logic [3:0] txPid,
  input wire logic txEmpty,
  input wire logic [7:0] txByte,
  input wire logic txByteValid,
  input wire logic txByteLast,
  output logic txByteReady,
  output logic txBusy
);
  typedef struct packed {
    logic [6:0] devAddr;
    logic [13:0] idx;
    logic [31:0] bits;
    logic [4:0] crc5;
    logic [15:0] crc16;
    logic [7:0] cur;
    logic [15:0] hold;
    logic [1:0] held;
    logic tokenHit;
    logic [3:0] tokenPid;
    logic [3:0] tokenEndp;
    logic sofSeen;
    logic [10:0] frameNum;
    logic splitSeen;
    logic splitComplete;
    logic [7:0] rxByte;
    logic rxByteValid;
    logic rxDone;
    logic rxCrcOk;
    logic crcErr;
  } funcRegs_t;

  funcRegs_t q;
  funcRegs_t next_q;
  logic [3:0] pid;
  logic pidOk;
  logic [6:0] rxAddr;
  logic [3:0] rxEndp;
  logic crc5Ok;
  logic crc16Ok;
  logic isToken;

  ////////////////////////////////////////////////////////////////
  function automatic logic endpUsable(input logic [3:0] endp, input logic [15:0] ready, input logic slow);
    if (endp == 4'h0) begin
      endpUsable = 1'b1;
    end else if (slow && (endp > token_crc_pkg::LOW_SPEED_MAX_ENDP)) begin
      endpUsable = 1'b0;
    end else begin
      endpUsable = ready[endp];
    end
  endfunction

  assign pid = q.bits[3:0];
  assign pidOk = (q.bits[7:4] == ~q.bits[3:0]) && (q.idx >= 14'(token_crc_pkg::PID_BITS));
  assign rxAddr = q.bits[token_crc_pkg::ADDR_LSB +: token_crc_pkg::ADDR_W];
  assign rxEndp = q.bits[token_crc_pkg::ENDP_LSB +: token_crc_pkg::ENDP_W];
  assign crc5Ok = (q.crc5 == token_crc_pkg::CRC5_RESIDUAL);
  assign crc16Ok = (q.crc16 == token_crc_pkg::CRC16_RESIDUAL);
  assign isToken = (pid == token_crc_pkg::PID_OUT) || (pid == token_crc_pkg::PID_IN)
                   || (pid == token_crc_pkg::PID_SETUP) || (pid == token_crc_pkg::PID_PING);

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    next_q.tokenHit = 1'b0;
    next_q.sofSeen = 1'b0;
    next_q.splitSeen = 1'b0;
    next_q.rxByteValid = 1'b0;
    next_q.rxDone = 1'b0;
    next_q.crcErr = 1'b0;
    if (setAddr) begin
      next_q.devAddr = newAddr;
    end
    if (link.hostValid) begin
      if (q.idx < 14'(token_crc_pkg::SPLIT_BITS)) begin
        next_q.bits[q.idx[4:0]] = link.hostBit;
      end
      if (q.idx != '1) begin
        next_q.idx = 14'(q.idx + 14'h0001);
      end
      if (q.idx >= 14'(token_crc_pkg::PID_BITS)) begin
        next_q.crc5 = token_crc_pkg::crc5Step(q.crc5, link.hostBit);
        next_q.crc16 = token_crc_pkg::crc16Step(q.crc16, link.hostBit);
        next_q.cur = {link.hostBit, q.cur[7:1]};
        if (q.idx[2:0] == 3'h7) begin
          next_q.hold = {next_q.cur, q.hold[15:8]};
          if (q.held == 2'h2) begin
            if (pidOk && token_crc_pkg::pidIsData(pid)) begin
              next_q.rxByte = q.hold[7:0];
              next_q.rxByteValid = 1'b1;
            end
          end else begin
            next_q.held = 2'(q.held + 2'h1);
          end
        end
      end
    end
    if (link.hostEop) begin
      if (pidOk && isToken && (q.idx == 14'(token_crc_pkg::TOKEN_BITS))) begin
        if (!crc5Ok) begin
          next_q.crcErr = 1'b1;
        end else if ((rxAddr == q.devAddr) && endpUsable(rxEndp, epReady, lowSpeed)) begin
          next_q.tokenHit = 1'b1;
          next_q.tokenPid = pid;
          next_q.tokenEndp = rxEndp;
        end
      end else if (pidOk && (pid == token_crc_pkg::PID_SOF) && (q.idx == 14'(token_crc_pkg::TOKEN_BITS))) begin
        if (crc5Ok) begin
          next_q.sofSeen = 1'b1;
          next_q.frameNum = q.bits[token_crc_pkg::FRAME_LSB +: token_crc_pkg::FRAME_W];
        end else begin
          next_q.crcErr = 1'b1;
        end
      end else if (pidOk && (pid == token_crc_pkg::PID_SPLIT) && (q.idx == 14'(token_crc_pkg::SPLIT_BITS))) begin
        if (!crc5Ok) begin
          next_q.crcErr = 1'b1;
        end else if (rxAddr == q.devAddr) begin
          next_q.splitSeen = 1'b1;
          next_q.splitComplete = q.bits[token_crc_pkg::SPLIT_SC_BIT];
        end
      end else if (pidOk && token_crc_pkg::pidIsData(pid) && (q.idx[2:0] == 3'h0)
                   && (q.idx >= 14'(token_crc_pkg::PID_BITS + 16))
                   && (q.idx <= 14'(token_crc_pkg::MAX_DATA_BITS))) begin
        next_q.rxDone = 1'b1;
        next_q.rxCrcOk = crc16Ok;
        next_q.crcErr = !crc16Ok;
      end
      next_q.idx = 14'h0000;
      next_q.crc5 = token_crc_pkg::CRC5_SEED;
      next_q.crc16 = token_crc_pkg::CRC16_SEED;
      next_q.held = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.devAddr <= token_crc_pkg::DEFAULT_ADDR;
      q.crc5 <= token_crc_pkg::CRC5_SEED;
      q.crc16 <= token_crc_pkg::CRC16_SEED;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  packet_sender sender (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(txStart),
    .pid(txPid),
    .isData(1'b1),
    .noData(txEmpty),
    .body(19'h00000),
    .bodyBits(5'h00),
    .byteData(txByte),
    .byteValid(txByteValid),
    .byteLast(txByteLast),
    .byteReady(txByteReady),
    .linkBit(link.devBit),
    .linkValid(link.devValid),
    .linkEop(link.devEop),
    .busy(txBusy)
  );

  assign devAddr = q.devAddr;
  assign tokenHit = q.tokenHit;
  assign tokenPid = q.tokenPid;
  assign tokenEndp = q.tokenEndp;
  assign sofSeen = q.sofSeen;
  assign frameNum = q.frameNum;
  assign splitSeen = q.splitSeen;
  assign splitComplete = q.splitComplete;
  assign rxByte = q.rxByte;
  assign rxByteValid = q.rxByteValid;
  assign rxDone = q.rxDone;
  assign rxCrcOk = q.rxCrcOk;
  assign crcErr = q.crcErr;
endmodule

// file: token_field_crc_checker.sv
// Link checker for both ends
`timescale 1ns/1ps
module token_field_crc_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hostBit,
  input wire logic hostValid,
  input wire logic hostEop,
  input wire logic devBit,
  input wire logic devValid,
  input wire logic devEop
);
  int hCnt;
  int dCnt;
  logic [7:0] hPid;
  logic [7:0] dPid;
  logic [4:0] hC5;
  logic [15:0] hC16;
  logic [15:0] dC16;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // Counts and remainders
  always_ff @(posedge clk) begin
    if (sys_rst || hostEop) begin
      hCnt <= 0;
      hC5 <= 5'h1f;
      hC16 <= 16'hffff;
    end else if (hostValid) begin
      hCnt <= hCnt + 1;
      if (hCnt < 8) begin
        hPid[hCnt[2:0]] <= hostBit;
      end else begin
        hC5 <= {hC5[3:0], 1'b0} ^ ((hC5[4] ^ hostBit) ? 5'h05 : 5'h00);
        hC16 <= {hC16[14:0], 1'b0} ^ ((hC16[15] ^ hostBit) ? 16'h8005 : 16'h0000);
      end
    end
    if (sys_rst || devEop) begin
      dCnt <= 0;
      dC16 <= 16'hffff;
    end else if (devValid) begin
      dCnt <= dCnt + 1;
      if (dCnt < 8) begin
        dPid[dCnt[2:0]] <= devBit;
      end else begin
        dC16 <= {dC16[14:0], 1'b0} ^ ((dC16[15] ^ devBit) ? 16'h8005 : 16'h0000);
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Assertions
  sequence quietTwo(v);
    !v ##1 !v;
  endsequence
  chk_host_pid_check: assert property (hostValid && hCnt >= 4 && hCnt < 8 |-> hostBit == !hPid[hCnt - 4])
    else $error("host pid check bits");
  chk_dev_pid_check: assert property (devValid && dCnt >= 4 && dCnt < 8 |-> devBit == !dPid[dCnt - 4])
    else $error("function pid check bits");
  chk_token_residual: assert property (hostEop && hPid[1:0] != 2'b11 |-> hC5 == 5'h0c)
    else $error("token residual wrong");
  chk_token_length: assert property (hostEop && hPid[1:0] != 2'b11 |-> hCnt == 24 || hCnt == 32)
    else $error("token length wrong");
  chk_host_data_residual: assert property (hostEop && hPid[1:0] == 2'b11 |-> hC16 == 16'h800d)
    else $error("host data residual wrong");
  chk_dev_data_residual: assert property (devEop |-> dC16 == 16'h800d)
    else $error("function data residual wrong");
  chk_dev_whole_bytes: assert property (devEop |-> dCnt % 8 == 0 && dCnt >= 24 && dCnt <= 8216)
    else $error("function data length");
  chk_dev_no_token: assert property (devValid && dCnt == 2 |-> dPid[1:0] == 2'b11)
    else $error("function sent non-data");
  chk_eop_gap: assert property (hostEop |-> !hostValid ##1 quietTwo(hostValid))
    else $error("no gap after host eop");
  chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !hostValid && !hostEop && !devValid && !devEop)
    else $error("link active after reset");
endmodule

// file: token_field_crc_checker_bench.sv
// Bench for the host and function ends
`timescale 1ns/1ps
module token_field_crc_checker_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] tokenPid = 4'h0;
  logic [6:0] tokenAddr = 7'h00;
  logic [3:0] tokenEndp = 4'h0;
  logic [4:0] start = 5'h00;
  logic [18:0] splitBody = 19'h00000;
  logic [3:0] dataPid = 4'h3;
  logic dataEmpty = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic txByteValid = 1'b0;
  logic txByteLast = 1'b0;
  logic setAddr = 1'b0;
  logic [6:0] newAddr = 7'h00;
  logic [15:0] epReady = 16'hffff;
  logic lowSpeed = 1'b0;
  logic hReady, hBusy, hDone, hOk, hByteValid, fReady, fBusy, fHit, fSof, fSplit, fSc;
  logic fByteValid, fDone, fOk, fErr, gHit, gErr;
  logic [10:0] hFrame, fFrame;
  logic [7:0] hByte, fByte;
  logic [6:0] devAddr;
  logic [3:0] fPid, fEndp;
  logic [7:0] pat [4] = '{8'ha5, 8'h01, 8'hff, 8'h80};
  logic [3:0] pids [4] = '{token_crc_pkg::PID_OUT, token_crc_pkg::PID_IN, token_crc_pkg::PID_SETUP,
    token_crc_pkg::PID_PING};
  logic [7:0] hq [$];
  logic [7:0] fq [$];
  logic [15:0] cnt [8] = '{default: 16'h0000};
  int exp [8];
  int n_fail = 0;
  int samples_checked = 0;
  serial_link_if lnk ();
  serial_link_if lnk2 ();
  ////////////////////////////////////////////////////////////////
  host_end i_host_end (.clk(clk), .sys_rst(sys_rst), .link(lnk), .tokenStart(start[0]), .tokenPid(tokenPid),
    .tokenAddr(tokenAddr), .tokenEndp(tokenEndp), .sofStart(start[1]), .splitStart(start[2]),
    .splitBody(splitBody), .dataStart(start[3]), .dataPid(dataPid), .dataEmpty(dataEmpty), .txByte(txByte),
    .txByteValid(txByteValid), .txByteLast(txByteLast), .txByteReady(hReady), .busy(hBusy), .frameNum(hFrame),
    .rxByte(hByte), .rxByteValid(hByteValid), .rxDone(hDone), .rxCrcOk(hOk));
  function_end i_function_end (.clk(clk), .sys_rst(sys_rst), .link(lnk), .setAddr(setAddr), .newAddr(newAddr),
    .epReady(epReady), .lowSpeed(lowSpeed), .devAddr(devAddr), .tokenHit(fHit), .tokenPid(fPid),
    .tokenEndp(fEndp), .sofSeen(fSof), .frameNum(fFrame), .splitSeen(fSplit), .splitComplete(fSc),
    .rxByte(fByte), .rxByteValid(fByteValid), .rxDone(fDone), .rxCrcOk(fOk), .crcErr(fErr), .txStart(start[4]),
    .txPid(dataPid), .txEmpty(dataEmpty), .txByte(txByte), .txByteValid(txByteValid), .txByteLast(txByteLast),
    .txByteReady(fReady), .txBusy(fBusy));
  function_end i_function_end_b (.clk(clk), .sys_rst(sys_rst), .link(lnk2), .setAddr(setAddr),
    .newAddr(newAddr), .epReady(epReady), .lowSpeed(lowSpeed), .devAddr(), .tokenHit(gHit), .tokenPid(),
    .tokenEndp(), .sofSeen(), .frameNum(), .splitSeen(), .splitComplete(), .rxByte(), .rxByteValid(), .rxDone(),
    .rxCrcOk(), .crcErr(gErr), .txStart(1'b0), .txPid(dataPid), .txEmpty(dataEmpty), .txByte(txByte),
    .txByteValid(txByteValid), .txByteLast(txByteLast), .txByteReady(), .txBusy());
  token_field_crc_checker i_token_field_crc_checker (.clk(clk), .sys_rst(sys_rst), .hostBit(lnk.hostBit),
    .hostValid(lnk.hostValid), .hostEop(lnk.hostEop), .devBit(lnk.devBit), .devValid(lnk.devValid),
    .devEop(lnk.devEop));
  ////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  always @(posedge clk) if (!sys_rst) begin
    cnt[0] += fHit;
    cnt[1] += fSof;
    cnt[2] += fSplit;
    cnt[3] += fErr;
    cnt[4] += fDone;
    cnt[5] += hDone;
    cnt[6] += gHit;
    cnt[7] += gErr;
    if (fByteValid) fq.push_back(fByte);
    if (hByteValid) hq.push_back(hByte);
  end
  ////////////////////////////////////////////////////////////////
  task automatic cmpVal(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic cmpStream(input logic [7:0] q [$], input int n);
    cmpVal(16'(q.size()), 16'(n));
    for (int i = 0; i < n && i < q.size(); i++) cmpVal(16'(q[i]), 16'(pat[i]));
  endtask
  task automatic checkAll();
    foreach (cnt[i]) cmpVal(cnt[i], 16'(exp[i]));
  endtask
  // One transfer: start, bytes, wait idle
  task automatic xfer(input int k, input int nb);
    dataEmpty = (nb == 0);
    @(negedge clk);
    start[k] = 1'b1;
    @(negedge clk);
    start = 5'h00;
    for (int i = 0; i < nb; i++) begin
      txByte = pat[i];
      txByteLast = (i == nb - 1);
      txByteValid = 1'b1;
      while (((k == 4) ? fReady : hReady) !== 1'b1) @(negedge clk);
      @(negedge clk);
    end
    txByteValid = 1'b0;
    while (hBusy !== 1'b0 || fBusy !== 1'b0) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  task automatic tok(input logic [3:0] p, input logic [6:0] a, input logic [3:0] e);
    tokenPid = p;
    tokenAddr = a;
    tokenEndp = e;
    xfer(0, 0);
  endtask
  // Raw bits on the second link, then end of packet
  task automatic raw(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      lnk2.hostBit = v[i];
      lnk2.hostValid = 1'b1;
    end
    @(negedge clk);
    lnk2.hostValid = 1'b0;
    lnk2.hostEop = 1'b1;
    @(negedge clk);
    lnk2.hostEop = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  function automatic logic [31:0] mkTok(input logic [3:0] p, input logic [10:0] body);
    logic [4:0] r;
    r = 5'h1f;
    for (int i = 0; i < 11; i++) begin
      r = {r[3:0], 1'b0} ^ ((r[4] ^ body[i]) ? 5'h05 : 5'h00);
    end
    mkTok = {8'h00, ~r[0], ~r[1], ~r[2], ~r[3], ~r[4], body, ~p, p};
  endfunction
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    lnk2.hostBit = 1'b0;
    lnk2.hostValid = 1'b0;
    lnk2.hostEop = 1'b0;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    cmpVal(16'(devAddr), 16'h0000);
    cmpVal(16'(hFrame), 16'h0000);
    foreach (pids[i]) begin
      tok(pids[i], 7'h00, 4'h0);
      exp[0]++;
      checkAll();
      cmpVal(16'(fPid), 16'(pids[i]));
      cmpVal(16'(fEndp), 16'h0000);
    end
    setAddr = 1'b1;
    newAddr = 7'h7f;
    @(negedge clk);
    setAddr = 1'b0;
    @(negedge clk);
    cmpVal(16'(devAddr), 16'h007f);
    tok(token_crc_pkg::PID_IN, 7'h00, 4'h0);
    checkAll();
    tok(token_crc_pkg::PID_IN, 7'h7f, 4'hf);
    exp[0]++;
    checkAll();
    cmpVal(16'(fEndp), 16'h000f);
    epReady = 16'hffdf;
    tok(token_crc_pkg::PID_OUT, 7'h7f, 4'h5);
    checkAll();
    lowSpeed = 1'b1;
    tok(token_crc_pkg::PID_OUT, 7'h7f, 4'h3);
    checkAll();
    tok(token_crc_pkg::PID_OUT, 7'h7f, 4'h2);
    exp[0]++;
    checkAll();
    lowSpeed = 1'b0;
    epReady = 16'hffff;
    for (int i = 0; i < 2; i++) begin
      xfer(1, 0);
      exp[1]++;
      checkAll();
      cmpVal(16'(fFrame), 16'(i));
    end
    cmpVal(16'(hFrame), 16'h0002);
    for (int i = 0; i < 2; i++) begin
      splitBody = {11'h000, i[0], 7'h7f};
      xfer(2, 0);
      exp[2]++;
      checkAll();
      cmpVal(16'(fSc), 16'(i));
    end
    dataPid = token_crc_pkg::PID_DATA1;
    xfer(3, 4);
    exp[4]++;
    checkAll();
    cmpVal(16'(fOk), 16'h0001);
    cmpStream(fq, 4);
    fq.delete();
    xfer(3, 0);
    exp[4]++;
    checkAll();
    cmpVal(16'(fOk), 16'h0001);
    cmpStream(fq, 0);
    xfer(4, 4);
    exp[5]++;
    checkAll();
    cmpVal(16'(hOk), 16'h0001);
    cmpStream(hq, 4);
    raw(mkTok(token_crc_pkg::PID_IN, {4'h1, 7'h7f}), 24);
    exp[6]++;
    checkAll();
    raw(mkTok(token_crc_pkg::PID_IN, {4'h1, 7'h7f}) ^ 32'h00800000, 24);
    exp[7]++;
    checkAll();
    raw(mkTok(token_crc_pkg::PID_IN, {4'h1, 7'h7f}), 23);
    checkAll();
    raw(mkTok(token_crc_pkg::PID_IN, {4'h1, 7'h7f}), 25);
    checkAll();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule
